/* File: design/rm_seq.sv */
// Two-channel resistance measurement sequencer with APB registers
`timescale 1ns/1ps
module rm_seq (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic PD_STROBE,
   input wire logic CW_ENABLE,
   input wire rm_seq_pkg::ctrl_s CW0,
   input wire rm_seq_pkg::ctrl_s CW1,
   input wire logic [23:0] ADC_DATA,
   input wire logic ADC_VALID,
   output logic ADC_CH,
   output logic ADC_2WIRE,
   output logic [3:0] ADC_RANGE,
   output logic ADC_RUN,
   output logic [1:0] LED_ON,
   output rm_seq_pkg::stat_s STAT0,
   output rm_seq_pkg::stat_s STAT1,
   output logic [23:0] VALUE0,
   output logic [23:0] VALUE1
);
   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_CONV = 2'b01, S_DONE = 2'b10
   } st_e;

   st_e state_q;
   logic cur_q;
   logic [31:0] cfg_q [2];
   logic [1:0] cfg_shot_q;
   logic [1:0] start_prev_q;
   logic [1:0] pend_q;
   logic [1:0] fresh_q;
   logic last_q;
   logic [23:0] cnt_q;
   logic [47:0] acc_q;
   logic [23:0] nsmp_q;
   logic [3:0] range_q [2];
   rm_seq_pkg::stat_s stat_q [2];
   logic [23:0] value_q [2];
   logic [1:0] mode_prev_q;

   // Effective control source per channel
   logic [1:0] mode [2];
   logic [1:0] autor;
   logic [3:0] man_range [2];
   logic [1:0] start_bit;
   logic [1:0] cont;
   logic [23:0] conv_cyc [2];
   logic [23:0] filt_cyc [2];
   logic wr, rd;
   logic [15:0] cal_rdata;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         rm_seq_pkg::ctrl_s c;
         int unsigned f;
         c = (i == 0) ? CW0 : CW1;
         if (CW_ENABLE) begin // RULE1
            mode[i] = c.mode;
            autor[i] = ~c.auto_dis;
            man_range[i] = c.range;
            start_bit[i] = c.start;
         end else begin // RULE2
            mode[i] = cfg_q[i][rm_seq_pkg::CFG_MODE +: 2];
            autor[i] = cfg_q[i][rm_seq_pkg::CFG_AUTO];
            man_range[i] = cfg_q[i][rm_seq_pkg::CFG_RANGE +: 4]; // RULE13
            start_bit[i] = 1'b0;
         end
         cont[i] = ~mode[i][0]; // RULE3
         f = cfg_q[i][rm_seq_pkg::CFG_FILT +: 4];
         if (f >= rm_seq_pkg::FILT_N) begin
            f = rm_seq_pkg::FILT_DEFAULT;
         end
         filt_cyc[i] = 24'(rm_seq_pkg::FILT_US[f] * rm_seq_pkg::US_CYC); // RULE17
         conv_cyc[i] = filt_cyc[i] + 24'(cfg_q[i][rm_seq_pkg::CFG_DELAY +: 8]
            * rm_seq_pkg::DELAY_UNIT_US * rm_seq_pkg::US_CYC); // RULE16
      end
   end

   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && !PENABLE && !PWRITE;
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;

   // Configuration registers
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < 2; i++) begin // RULE19
            cfg_q[i] <= 32'h0;
            cfg_q[i][rm_seq_pkg::CFG_MODE +: 2] <= rm_seq_pkg::MODE_DEFAULT;
            cfg_q[i][rm_seq_pkg::CFG_RANGE +: 4] <= rm_seq_pkg::RANGE_DEFAULT;
            cfg_q[i][rm_seq_pkg::CFG_AUTO] <= 1'b1;
            cfg_q[i][rm_seq_pkg::CFG_FILT +: 4] <= rm_seq_pkg::FILT_DEFAULT;
            cfg_q[i][rm_seq_pkg::CFG_DELAY +: 8] <= rm_seq_pkg::DELAY_DEFAULT;
         end
         cfg_shot_q <= 2'b00;
      end else begin
         cfg_shot_q <= 2'b00;
         for (int i = 0; i < 2; i++) begin
            if (wr && PADDR == (i == 0 ? rm_seq_pkg::REG_CH0_CFG
                                       : rm_seq_pkg::REG_CH1_CFG)) begin
               cfg_q[i] <= PWDATA;
               cfg_shot_q[i] <= PWDATA[rm_seq_pkg::CFG_MODE] && !CW_ENABLE; // RULE9
            end
         end
      end
   end

   // Process data cycle sampling of the start bits
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         start_prev_q <= 2'b00;
      end else if (PD_STROBE) begin
         start_prev_q <= start_bit; // RULE23
      end
   end

   // Pending single-shot requests; a new request wins over the clear
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pend_q <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            logic req;
            req = (PD_STROBE && start_bit[i] && !start_prev_q[i]) // RULE6
                  || cfg_shot_q[i];
            if (req && !cont[i]) begin
               pend_q[i] <= 1'b1;
            end else if (cont[i] || (state_q == S_DONE && cur_q == i[0])) begin
               pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // Channel scheduler
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= S_IDLE;
         cur_q <= 1'b0;
         last_q <= 1'b1;
         cnt_q <= 24'h0;
      end else begin
         case (state_q)
            S_IDLE: begin
               cnt_q <= 24'h0;
               if (pend_q[0]) begin // RULE7 RULE8
                  cur_q <= 1'b0;
                  state_q <= S_CONV;
               end else if (pend_q[1]) begin
                  cur_q <= 1'b1;
                  state_q <= S_CONV;
               end else if (cont[0] && cont[1]) begin // RULE5
                  cur_q <= ~last_q;
                  state_q <= S_CONV;
               end else if (cont[0] || cont[1]) begin
                  cur_q <= cont[1];
                  state_q <= S_CONV;
               end
            end
            S_CONV: begin // RULE4
               if (cnt_q >= conv_cyc[cur_q] - 24'h1) begin
                  state_q <= S_DONE;
               end else begin
                  cnt_q <= cnt_q + 24'h1;
               end
            end
            S_DONE: begin
               last_q <= cur_q;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Delay first, then the averaging window of one filter period
   logic in_window;
   assign in_window = state_q == S_CONV &&
      cnt_q >= conv_cyc[cur_q] - filt_cyc[cur_q];

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         acc_q <= 48'h0;
         nsmp_q <= 24'h0;
      end else if (state_q != S_CONV) begin
         acc_q <= 48'h0;
         nsmp_q <= 24'h0;
      end else if (in_window && ADC_VALID) begin // RULE15
         acc_q <= acc_q + {24'h0, ADC_DATA};
         nsmp_q <= nsmp_q + 24'h1;
      end
   end

   logic [23:0] avg;
   assign avg = (nsmp_q == 24'h0) ? 24'h0
              : 24'(acc_q / {24'h0, nsmp_q});

   // Results, range stepping and status
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < 2; i++) begin
            value_q[i] <= 24'h0;
            range_q[i] <= rm_seq_pkg::RANGE_DEFAULT;
            stat_q[i] <= '0;
         end
         fresh_q <= 2'b00;
         mode_prev_q <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            logic [3:0] lo;
            mode_prev_q[i] <= mode[i][0];
            lo = mode[i][1] ? rm_seq_pkg::RANGE_2W_MIN : 4'h0; // RULE12
            if (!autor[i]) begin
               range_q[i] <= man_range[i]; // RULE13
            end else if (range_q[i] < lo) begin
               range_q[i] <= lo;
            end
            if (state_q == S_DONE && cur_q == i[0]) begin
               value_q[i] <= avg;
               stat_q[i].overrange <= avg > rm_seq_pkg::FULL_SCALE; // RULE10
               stat_q[i].underrange <= 1'b0;
               stat_q[i].error <= avg > rm_seq_pkg::FULL_SCALE;
               stat_q[i].invalid <= 1'b0;
               stat_q[i].range <= range_q[i];
               if (autor[i] && avg > rm_seq_pkg::FULL_SCALE
                   && range_q[i] < rm_seq_pkg::RANGE_MAX) begin // RULE11
                  range_q[i] <= range_q[i] + 4'h1;
                  stat_q[i].settled <= 1'b0;
               end else if (autor[i] && avg < rm_seq_pkg::LOW_LIMIT
                            && range_q[i] > lo) begin
                  range_q[i] <= range_q[i] - 4'h1;
                  stat_q[i].settled <= 1'b0;
               end else begin
                  stat_q[i].settled <= 1'b1;
               end
               if (!(cont[0] && cont[1])) begin
                  stat_q[i].toggle <= ~stat_q[i].toggle;
               end
            end
            // Last, so a switch in the finishing cycle still marks invalid
            if (mode[i][0] && !mode_prev_q[i]) begin
               stat_q[i].invalid <= 1'b1; // RULE22
               stat_q[i].settled <= 1'b0;
            end
         end
         // Alternating: publish toggles once both channels converted
         if (cont[0] && cont[1] && state_q == S_DONE) begin // RULE18
            if ((fresh_q | (2'b01 << cur_q)) == 2'b11) begin
               stat_q[0].toggle <= ~stat_q[0].toggle;
               stat_q[1].toggle <= ~stat_q[1].toggle;
               fresh_q <= 2'b00;
            end else begin
               fresh_q <= fresh_q | (2'b01 << cur_q);
            end
         end
      end
   end

   // Calibration storage access from APB
   logic cal_we;
   logic [6:0] cal_addr;
   // Indices past the last set are dropped, so a factory index never
   // lands in the user half
   assign cal_we = wr && PADDR == rm_seq_pkg::REG_CAL
      && PWDATA[rm_seq_pkg::CAL_IDX +: 6] < 6'(rm_seq_pkg::CAL_SETS);
   assign cal_addr = 7'(PWDATA[rm_seq_pkg::CAL_IDX +: 6])
      + (PWDATA[rm_seq_pkg::CAL_USER] ? 7'(rm_seq_pkg::CAL_SETS) : 7'h00);
   logic [6:0] cal_raddr_q;
   logic [6:0] cal_key_q;
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cal_raddr_q <= 7'h0;
         cal_key_q <= 7'h00;
      end else if (cal_we) begin
         cal_raddr_q <= cal_addr;
         cal_key_q <= {PWDATA[rm_seq_pkg::CAL_USER],
            PWDATA[rm_seq_pkg::CAL_IDX +: 6]};
      end
   end

   rm_cal_mem u_cal ( // RULE14
      .CLK(CLK),
      .we(cal_we),
      .waddr(cal_addr),
      .wdata(PWDATA[15:0]),
      .raddr(cal_raddr_q),
      .rdata(cal_rdata)
   );

   // Read data registered in setup so the access phase completes at once
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         PRDATA <= 32'h0;
      end else if (rd) begin
         case (PADDR)
            rm_seq_pkg::REG_CH0_CFG: PRDATA <= cfg_q[0];
            rm_seq_pkg::REG_CH1_CFG: PRDATA <= cfg_q[1];
            rm_seq_pkg::REG_STAT: PRDATA <= {12'h0, stat_q[1], stat_q[0]};
            rm_seq_pkg::REG_CH0_VAL: PRDATA <= {8'h0, value_q[0]};
            rm_seq_pkg::REG_CH1_VAL: PRDATA <= {8'h0, value_q[1]};
            rm_seq_pkg::REG_CAL: PRDATA <= {cal_key_q[6], 1'b0,
               cal_key_q[5:0], 8'h00, cal_rdata};
            rm_seq_pkg::REG_CTRL: PRDATA <= {28'h0, state_q, cur_q, CW_ENABLE};
            default: PRDATA <= 32'h0;
         endcase
      end
   end

   assign ADC_CH = cur_q;
   assign ADC_2WIRE = mode[cur_q][1];
   assign ADC_RANGE = range_q[cur_q];
   assign ADC_RUN = state_q == S_CONV;
   assign LED_ON[0] = ADC_RUN && !cur_q; // RULE5
   assign LED_ON[1] = ADC_RUN && cur_q;
   assign STAT0 = stat_q[0];
   assign STAT1 = stat_q[1];
   assign VALUE0 = value_q[0];
   assign VALUE1 = value_q[1];
endmodule

/* File: common/rm_seq_pkg.sv */
// Package with constants, types and encodings for the measurement sequencer
// Operation
// (RULE1) With control word enabled, disable/start/range/mode come only from it
// (RULE2) Otherwise autorange, range and wire mode come from configuration objects
// (RULE3) Mode 0 cont 4-wire, 1 shot 4-wire, 2 cont 2-wire, 3 shot 2-wire
// (RULE4) At most one channel converts at any moment
// (RULE5) Both continuous: alternate channels, status lamp lit while measuring
// (RULE6) Single-shot channel starts only on rising edge of start bit
// (RULE7) Simultaneous single-shot requests: channel 0 first, then channel 1
// (RULE8) Mixed: continuous channel yields only to pending single-shot request
// (RULE9) Writing mode 1 or 3 into configuration also triggers a measurement
// (RULE10) Broken wire shows only as sustained above-range on that channel
// (RULE11) Autorange picks a range in which the value can be represented
// (RULE12) Autorange in 2-wire never goes below range 2
// (RULE13) Lowest ranges in 2-wire stay manually selectable; user calibrates
// (RULE14) Keep 36 factory and 36 user gain/offset sets
// (RULE15) Average raw samples over one filter period per channel
// (RULE16) Conversion time equals filter period plus delay time
// (RULE17) Filter 2.5..100 Hz, periods 400 ms to 10 ms, default 10 Hz
// (RULE18) Alternating: each result refreshes after both channels converted
// (RULE19) Reset: continuous 4-wire, configuration objects, autorange on
// (RULE20) Master uses value only when settled and no fault or invalid flag
// (RULE21) Master may watch new-value toggle with input image state zero
// (RULE22) After continuous to single-shot switch, value invalid until request
// (RULE23) Start bit registered each process data cycle for edge detection
package rm_seq_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   // Filter periods in microseconds, index = filter code
   localparam int unsigned FILT_N = 9;
   localparam logic [3:0] FILT_DEFAULT = 4'h2;
   localparam int unsigned FILT_US [FILT_N] = '{400000, 200000, 100000,
      66667, 40000, 33333, 20000, 16667, 10000};
   localparam int unsigned DELAY_UNIT_US = 1000;
   localparam logic [7:0] DELAY_DEFAULT = 8'h0a;
   localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
   localparam int unsigned SAMPLE_US = 100;
   localparam int unsigned SAMPLE_CYC = SAMPLE_US * US_CYC;
   localparam int unsigned NRANGE = 9;
   localparam logic [3:0] RANGE_MAX = 4'h8;
   localparam logic [3:0] RANGE_2W_MIN = 4'h2;
   localparam logic [3:0] RANGE_DEFAULT = 4'h7;
   localparam int unsigned CAL_SETS = 36;
   localparam logic [23:0] FULL_SCALE = 24'h7fffff;
   localparam logic [23:0] LOW_LIMIT = 24'h0ccccc;
   localparam logic [1:0] MODE_DEFAULT = 2'h0;
   // APB register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CH0_CFG = 8'h04;
   localparam logic [7:0] REG_CH1_CFG = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam logic [7:0] REG_CH0_VAL = 8'h10;
   localparam logic [7:0] REG_CH1_VAL = 8'h14;
   localparam logic [7:0] REG_CAL = 8'h18;
   // CFG fields
   localparam int unsigned CFG_MODE = 0;
   localparam int unsigned CFG_RANGE = 4;
   localparam int unsigned CFG_AUTO = 8;
   localparam int unsigned CFG_FILT = 12;
   localparam int unsigned CFG_DELAY = 16;
   // CAL fields: set index, then user/factory select bit
   localparam int unsigned CAL_IDX = 24;
   localparam int unsigned CAL_USER = 31;

   typedef enum logic [1:0] {
      M_CONT4 = 2'b00, M_SHOT4 = 2'b01, M_CONT2 = 2'b10, M_SHOT2 = 2'b11
   } mode_e;

   // Cyclic control word per channel
   typedef struct packed {
      logic auto_dis;
      logic start;
      logic [3:0] range;
      logic [1:0] mode;
   } ctrl_s;

   // Per channel status
   typedef struct packed {
      logic invalid;
      logic settled;
      logic overrange;
      logic underrange;
      logic error;
      logic toggle;
      logic [3:0] range;
   } stat_s;
endpackage

/* File: design/rm_cal_mem.sv */
// Calibration store: factory and user gain/offset sets
`timescale 1ns/1ps
module rm_cal_mem (
   input wire logic CLK,
   input wire logic we,
   input wire logic [6:0] waddr,
   input wire logic [15:0] wdata,
   input wire logic [6:0] raddr,
   output logic [15:0] rdata
);
   // Low half factory, high half user sets
   logic [15:0] mem [2*rm_seq_pkg::CAL_SETS];

   always_ff @(posedge CLK) begin
      if (we && waddr < 7'(2*rm_seq_pkg::CAL_SETS)) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge CLK) begin
      if (raddr < 7'(2*rm_seq_pkg::CAL_SETS)) begin
         rdata <= mem[raddr];
      end else begin
         rdata <= 16'h0000;
      end
   end
endmodule

/* File: verif/rm_seq_assertions.sv */
// Port-level assertions for the resistance measurement sequencer
`timescale 1ns/1ps
module rm_seq_assertions (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic PD_STROBE,
   input wire logic CW_ENABLE,
   input wire rm_seq_pkg::ctrl_s CW0,
   input wire rm_seq_pkg::ctrl_s CW1,
   input wire logic ADC_CH,
   input wire logic ADC_2WIRE,
   input wire logic [3:0] ADC_RANGE,
   input wire logic ADC_RUN,
   input wire logic [1:0] LED_ON
);
   logic p0_q;
   logic p1_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // Start levels as last seen at a process data cycle
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p0_q <= 1'b0;
         p1_q <= 1'b0;
      end else if (PD_STROBE) begin
         p0_q <= CW0.start;
         p1_q <= CW1.start;
      end
   end
   sequence both_req;
      PD_STROBE && CW_ENABLE && CW0.mode[0] && CW1.mode[0] && !ADC_RUN
         && CW0.start && !p0_q && CW1.start && !p1_q;
   endsequence
   sequence ch0_first;
      ##[1:4] (ADC_RUN && !ADC_CH);
   endsequence
   a_shot_order: assert property (both_req |-> ch0_first)
      else $error("Channel 1 served first");
   a_no_overlap: assert property (LED_ON != 2'b11)
      else $error("Both channels converting");
   a_lamp_run: assert property (
      LED_ON == {ADC_RUN && ADC_CH, ADC_RUN && !ADC_CH})
      else $error("Lamp does not follow conversion");
   a_wire_mode: assert property (
      $rose(ADC_RUN) && CW_ENABLE && $past(CW_ENABLE)
      |-> ADC_2WIRE == (ADC_CH ? CW1.mode[1] : CW0.mode[1]))
      else $error("Wire mode differs from control word");
   logic floor_arm;
   assign floor_arm = ADC_RUN && ADC_2WIRE && CW_ENABLE
      && !(ADC_CH ? CW1.auto_dis : CW0.auto_dis);
   // The range register follows a mode or autorange change one cycle late
   a_auto_floor: assert property (
      floor_arm && $past(floor_arm)
      |-> ADC_RANGE >= rm_seq_pkg::RANGE_2W_MIN)
      else $error("Autorange below floor in 2-wire");
   a_reset_start: assert property (
      $rose(NRST) && !CW_ENABLE
      |-> ##[1:3] (ADC_RUN && !ADC_CH && !ADC_2WIRE))
      else $error("No 4-wire start on channel 0 after reset");
   a_apb_ready: assert property (PREADY && !PSLVERR)
      else $error("Bus slave stalled or flagged error");
   a_unmapped_zero: assert property (
      PSEL && !PENABLE && !PWRITE && PADDR > 8'h18 |=> PRDATA == 32'h0)
      else $error("Unmapped read not zero");
endmodule
bind rm_seq rm_seq_assertions u_chk (
   .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .PD_STROBE(PD_STROBE), .CW_ENABLE(CW_ENABLE),
   .CW0(CW0), .CW1(CW1), .ADC_CH(ADC_CH), .ADC_2WIRE(ADC_2WIRE),
   .ADC_RANGE(ADC_RANGE), .ADC_RUN(ADC_RUN), .LED_ON(LED_ON)
);

/* File: verif/rm_bus_model.sv */
// Fieldbus master and analog front end facing the sequencer
`timescale 1ns/1ps
module rm_bus_model #(
   parameter logic [23:0] SAMPLE = 24'h123456
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic cw_en,
   input wire rm_seq_pkg::ctrl_s req0,
   input wire rm_seq_pkg::ctrl_s req1,
   input wire logic ADC_RUN,
   input wire rm_seq_pkg::stat_s STAT0,
   output logic PD_STROBE,
   output logic CW_ENABLE,
   output rm_seq_pkg::ctrl_s CW0,
   output rm_seq_pkg::ctrl_s CW1,
   output logic [23:0] ADC_DATA,
   output logic ADC_VALID,
   output logic usable0
);
   logic [3:0] pd_q;
   logic [9:0] smp_q;
   logic hit;
   assign usable0 = STAT0.settled && !STAT0.error && !STAT0.invalid;
   assign hit = ADC_RUN && smp_q == 10'(rm_seq_pkg::SAMPLE_CYC - 1);
   // Outputs refresh once a cycle, so a start level stands a whole cycle
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pd_q <= 4'h0;
         PD_STROBE <= 1'b0;
         CW_ENABLE <= cw_en;
         CW0 <= req0;
         CW1 <= req1;
      end else begin
         pd_q <= pd_q + 4'h1;
         PD_STROBE <= pd_q == 4'he;
         if (PD_STROBE) begin
            CW_ENABLE <= cw_en;
            CW0 <= req0;
            CW1 <= req1;
         end
      end
   end
   // Between samples the data lines move, so stale data never looks valid
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         smp_q <= 10'h0;
         ADC_VALID <= 1'b0;
         ADC_DATA <= 24'h0;
      end else begin
         smp_q <= (ADC_RUN && !hit) ? smp_q + 10'h1 : 10'h0;
         ADC_VALID <= hit;
         ADC_DATA <= hit ? SAMPLE : ~ADC_DATA;
      end
   end
endmodule

/* File: verif/test_resistance_measurement_sequencer.sv */
// Self-checking bench for the resistance measurement sequencer
`timescale 1ns/1ps
module test_resistance_measurement_sequencer;
   localparam logic [31:0] CFG_DEF = {8'h00, rm_seq_pkg::DELAY_DEFAULT,
      rm_seq_pkg::FILT_DEFAULT, 4'h1, rm_seq_pkg::RANGE_DEFAULT, 2'h0,
      rm_seq_pkg::MODE_DEFAULT};
   logic CLK = 1'b0;
   logic NRST = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA, q;
   logic PREADY, PSLVERR, PD_STROBE, CW_ENABLE, ADC_VALID, ADC_CH;
   logic ADC_2WIRE, ADC_RUN, usable0;
   logic cw_en = 1'b0;
   logic [3:0] ADC_RANGE;
   logic [1:0] LED_ON;
   logic [23:0] ADC_DATA, VALUE0, VALUE1;
   rm_seq_pkg::ctrl_s CW0, CW1;
   rm_seq_pkg::ctrl_s req0 = '0;
   rm_seq_pkg::ctrl_s req1 = '0;
   rm_seq_pkg::stat_s STAT0, STAT1;
   int bad_count = 0;
   int checks = 0;
   always #50 CLK = ~CLK;
   rm_seq u_dut (.*);
   rm_bus_model u_bus (.*);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic fail();
      bad_count++;
      complete_run();
   endtask
   task automatic tick();
      @(posedge CLK);
      #1;
   endtask
   // One APB transfer; read data lands in q
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      q = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (PREADY !== 1'b1) fail();
   endtask
   // Waits for the conversion flag to reach lvl; n counts the cycles
   task automatic wait_run(input logic lvl, input int lim, output int n);
      n = 0;
      while (ADC_RUN !== lvl && n < lim) begin
         tick();
         n++;
      end
      if (ADC_RUN !== lvl) fail();
   endtask
   task automatic test_reset();
      int n;
      repeat (20) @(posedge CLK);
      check({STAT0, STAT1, ADC_RUN}, 32'h0);
      NRST <= 1'b1;
      wait_run(1'b1, 5, n);
      check({ADC_CH, ADC_2WIRE, LED_ON, ADC_RANGE}, 8'h17);
      apb(1'b0, 8'h04, 32'h0);
      check(q, CFG_DEF);
      apb(1'b0, 8'h08, 32'h0);
      check(q, CFG_DEF);
      $display("reset test done");
   endtask
   task automatic test_regs();
      apb(1'b1, 8'h08, 32'h00008122);
      apb(1'b0, 8'h08, 32'h0);
      check(q, 32'h00008122);
      apb(1'b1, 8'h18, 32'ha3005a5a);
      apb(1'b0, 8'h18, 32'h0);
      check(q, 32'ha3005a5a);
      apb(1'b1, 8'h1c, 32'hffffffff);
      apb(1'b0, 8'h1c, 32'h0);
      check(q, 32'h0);
      $display("register test done");
   endtask
   // Control word selects single shot while the objects still say continuous
   task automatic test_shot();
      int n;
      @(posedge CLK);
      NRST <= 1'b0;
      cw_en <= 1'b1;
      req0 <= 8'h01;
      req1 <= 8'h03;
      repeat (3) @(posedge CLK);
      NRST <= 1'b1;
      apb(1'b1, 8'h04, 32'h00008170);
      apb(1'b1, 8'h08, 32'h00008170);
      n = 0;
      repeat (40) begin
         tick();
         if (ADC_RUN !== 1'b0) n++;
      end
      check(n, 0);
      @(posedge CLK);
      req0 <= 8'h41;
      req1 <= 8'h43;
      wait_run(1'b1, 100, n);
      check({ADC_CH, LED_ON}, 3'b001);
      wait_run(1'b0, 120000, n);
      check(n, rm_seq_pkg::FILT_US[8] * rm_seq_pkg::US_CYC);
      repeat (2) tick();
      q = {STAT0.toggle, STAT0.invalid, STAT0.overrange, STAT0.range};
      check(q, 32'h47);
      check(VALUE0, 24'h123456);
      check(usable0, 1'b1);
      wait_run(1'b1, 20, n);
      check({ADC_CH, ADC_2WIRE, LED_ON}, 4'b1110);
      check(ADC_RANGE >= 4'h2, 1'b1);
      // Manual low range in 2-wire, then autorange lifts it to the floor
      @(posedge CLK);
      req1 <= 8'h83;
      repeat (40) tick();
      check({ADC_CH, ADC_RANGE}, 5'h10);
      @(posedge CLK);
      req1 <= 8'h03;
      repeat (40) tick();
      check(ADC_RANGE, rm_seq_pkg::RANGE_2W_MIN);
      $display("single shot test done");
   endtask
   initial begin
      test_reset();
      test_regs();
      test_shot();
      complete_run();
   end
endmodule
